// ### src/hps_pkg.sv
// Shared constants for the host port with strap-selected serial or parallel access.
package hps_pkg;
  // System clock and reset timing.
  localparam int CLK_PERIOD_NS = 100;
  localparam int RST_MIN_NS    = 500;
  localparam int RST_MIN_CYC   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_TIME_NS  = 60300000;
  localparam int INIT_CYC_DEF  = INIT_TIME_NS / CLK_PERIOD_NS;

  // Widths and depths.
  localparam int DATA_W     = 8;
  localparam int ADDR_W     = 2;
  localparam int KIND_W     = 2;
  localparam int REQ_W      = KIND_W + ADDR_W + DATA_W;
  localparam int FIFO_DEPTH = 4;
  localparam int INIT_CNT_W = 20;
  localparam int RST_CNT_W  = 3;
  localparam int BIT_CNT_W  = 3;

  // Request kinds carried in the request stream.
  localparam logic [KIND_W-1:0] KIND_PAR_READ  = 2'h0;
  localparam logic [KIND_W-1:0] KIND_PAR_WRITE = 2'h1;
  localparam logic [KIND_W-1:0] KIND_SPI_BYTE  = 2'h2;

  // Positions of the sampled inputs in the synchroniser vector.
  localparam int PIN_RSTIN = 0;
  localparam int PIN_D_LO  = 1;
  localparam int PIN_A0    = 9;
  localparam int PIN_A1    = 10;
  localparam int PIN_WR    = 11;
  localparam int PIN_RD    = 12;
  localparam int PIN_CS    = 13;
  localparam int PIN_STRAP = 14;
  localparam int PIN_TGL   = 15;
  localparam int PIN_W     = 16;
  localparam logic [PIN_W-1:0] PIN_IDLE = 16'h3801;

  // Serial bit counter landmarks.
  localparam logic [BIT_CNT_W-1:0] BIT_ZERO  = 3'h0;
  localparam logic [BIT_CNT_W-1:0] BIT_ONE   = 3'h1;
  localparam logic [BIT_CNT_W-1:0] BIT_LAST  = 3'h7;
  localparam logic [DATA_W-1:0]    BYTE_ZERO = 8'h00;
endpackage : hps_pkg

// ### src/hps_top.sv
// Request FIFO and the host port top level with serial and parallel front ends.
`timescale 1ns/1ns
// Overview of operation
// R1: Strap low selects serial access, strap high selects the parallel bus.
// R2: Serial clock clocks the link in serial mode; held low in parallel mode.
// R3: Shared input is serial data in, or address bit zero in parallel mode.
// R4: Shared two-way line drives serial data out, or is address bit one input.
// R5: Low read strobe marks a parallel read; held high in serial mode.
// R6: Low write strobe marks a parallel write from the host.
// R7: Eight-bit data bus is two-way in parallel mode, undriven in serial mode.
// R8: Interrupt output low while an enabled event is pending, high otherwise.
// R9: Host holds reset input low longer than 500 ns to initialize.
// R10: Initialization completes within 60.3 ms; no accesses accepted before that.
// R11: Serial transfers work in clock mode 0 and clock mode 3.
// R12: Parallel bus is two address bits and eight data bits, indirect access.
// R13: Transfers are answered only while chip select is low.

// Small synchronous FIFO built from flip-flops.
module hps_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;
  localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready  = (count != FULL);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage is written only on an accepted push.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap explicitly so that any depth works.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + CNT_W'(push) - CNT_W'(pop);
    end
  end
endmodule : hps_fifo

// Host port: strap-selected serial or parallel access feeding one request stream.
module hps_top
  import hps_pkg::*;
#(
  parameter int INIT_CYCLES = INIT_CYC_DEF
) (
  input  wire logic              CLK_SYS,
  input  wire logic              RST,
  input  wire logic              SCLK,
  input  wire logic              IFACE_MODE_STRAP,
  input  wire logic              CHIP_SEL_N,
  input  wire logic              RESET_IN_N,
  input  wire logic              READ_STROBE_N,
  input  wire logic              WRITE_STROBE_N,
  input  wire logic              ADDR_BIT0,
  input  wire logic              ADDR_BIT1_I,
  output logic                   ADDR_BIT1_O,
  output logic                   ADDR_BIT1_OE,
  input  wire logic [DATA_W-1:0] HOST_DATA_BUS_I,
  output logic      [DATA_W-1:0] HOST_DATA_BUS_O,
  output logic                   HOST_DATA_BUS_OE,
  output logic                   IRQ_OUT_N,
  input  wire logic              IRQ_PENDING,
  input  wire logic              IRQ_PIN_ENABLE,
  output logic                   READY,
  output logic                   PAR_MODE,
  output logic                   REQ_VALID,
  input  wire logic              REQ_READY,
  output logic      [KIND_W-1:0] REQ_KIND,
  output logic      [ADDR_W-1:0] REQ_ADDR,
  output logic      [DATA_W-1:0] REQ_DATA,
  input  wire logic              RSP_VALID,
  input  wire logic [DATA_W-1:0] RSP_DATA
);
  logic [PIN_W-1:0]     pins;
  logic [PIN_W-1:0]     s1;
  logic [PIN_W-1:0]     s2;
  logic [PIN_W-1:0]     s3;
  logic [PIN_W-1:0]     f;
  logic [RST_CNT_W-1:0] rst_cnt;
  logic                 host_rst;
  logic [INIT_CNT_W-1:0] init_cnt;
  logic                 ready;
  logic                 par_mode;
  logic                 prev_rd;
  logic                 prev_wr;
  logic                 fall_rd;
  logic                 fall_wr;
  logic                 par_ev;
  logic                 spi_ev;
  logic                 tgl_new;
  logic                 seen;
  logic                 pend_v;
  logic [REQ_W-1:0]     pend_w;
  logic                 fifo_in_ready;
  logic [REQ_W-1:0]     fifo_out;
  logic [DATA_W-1:0]    tx_hold;
  logic                 link_rst;
  logic [BIT_CNT_W-1:0] bit_cnt;
  logic [DATA_W-1:0]    rx_sh;
  logic [DATA_W-1:0]    tx_sh;
  logic                 link_tgl;
  logic [DATA_W-1:0]    rx_slot [2];

  // Every asynchronous input except the serial clock, including the link toggle, goes into one vector.
  assign pins = {link_tgl, IFACE_MODE_STRAP, CHIP_SEL_N, READ_STROBE_N, WRITE_STROBE_N,
                 ADDR_BIT1_I, ADDR_BIT0, HOST_DATA_BUS_I, RESET_IN_N};

  // Three stages per bit; a change counts only once stages two and three agree.
  for (genvar i = 0; i < PIN_W; i++) begin : g_sync
    always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
        s1[i] <= PIN_IDLE[i];
        s2[i] <= PIN_IDLE[i];
        s3[i] <= PIN_IDLE[i];
        f[i]  <= PIN_IDLE[i];
      end else begin
        s1[i] <= pins[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
        if (s2[i] == s3[i]) begin
          f[i] <= s3[i];
        end
      end
    end
  end

  // Short glitches on the reset pin are ignored; a long enough low restarts init.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rst_cnt <= '0;
    end else if (f[PIN_RSTIN]) begin
      rst_cnt <= '0;
    end else if (!host_rst) begin
      rst_cnt <= rst_cnt + 1'b1;
    end
  end
  assign host_rst = (rst_cnt == RST_CNT_W'(RST_MIN_CYC)); // [R9]

  // Initialization timer; nothing is accepted until it has run out.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      init_cnt <= '0;
      ready    <= 1'b0;
    end else if (host_rst) begin
      init_cnt <= '0;
      ready    <= 1'b0;
    end else if (!ready) begin
      init_cnt <= init_cnt + 1'b1;
      ready    <= (init_cnt == INIT_CNT_W'(INIT_CYCLES - 1)); // [R10]
    end
  end

  // The strap is followed during init and frozen once ready, so a late change is harmless.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      par_mode <= 1'b0;
    end else if (!ready) begin
      par_mode <= f[PIN_STRAP]; // [R1]
    end
  end

  // Strobe edges are taken from the filtered copies, never from raw pins.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      prev_rd <= 1'b1;
      prev_wr <= 1'b1;
    end else begin
      prev_rd <= f[PIN_RD];
      prev_wr <= f[PIN_WR];
    end
  end
  assign fall_rd = prev_rd && !f[PIN_RD]; // [R5]
  assign fall_wr = prev_wr && !f[PIN_WR]; // [R6]
  assign par_ev  = ready && par_mode && !f[PIN_CS] && (fall_rd || fall_wr); // [R13]

  // A new serial byte shows as a change of the crossed toggle.
  assign tgl_new = (f[PIN_TGL] != seen);
  assign spi_ev  = tgl_new && ready && !par_mode;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      seen <= 1'b0;
    end else if (tgl_new) begin
      seen <= f[PIN_TGL];
    end
  end

  // One-entry holding stage in front of the FIFO; a new event wins over the drain.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pend_v <= 1'b0;
      pend_w <= '0;
    end else if (par_ev) begin
      pend_v <= 1'b1;
      pend_w <= {fall_wr ? KIND_PAR_WRITE : KIND_PAR_READ, f[PIN_A1], f[PIN_A0], // [R3] [R12]
                 fall_wr ? f[PIN_D_LO +: DATA_W] : BYTE_ZERO}; // [R7]
    end else if (spi_ev) begin
      pend_v <= 1'b1;
      pend_w <= {KIND_SPI_BYTE, {ADDR_W{1'b0}}, rx_slot[f[PIN_TGL]]}; // [R11]
    end else if (pend_v && fifo_in_ready) begin
      pend_v <= 1'b0;
    end
  end

  // The FIFO decouples the host pins from a slow request consumer.
  hps_fifo #(
    .WIDTH (REQ_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK_SYS),
    .rst       (RST),
    .in_valid  (pend_v),
    .in_ready  (fifo_in_ready),
    .in_data   (pend_w),
    .out_valid (REQ_VALID),
    .out_ready (REQ_READY),
    .out_data  (fifo_out)
  );
  assign REQ_DATA = fifo_out[DATA_W-1:0];
  assign REQ_ADDR = fifo_out[DATA_W +: ADDR_W];
  assign REQ_KIND = fifo_out[DATA_W+ADDR_W +: KIND_W];

  // Answer data is held for both the parallel bus and the serial shifter.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      tx_hold <= BYTE_ZERO;
    end else if (RSP_VALID) begin
      tx_hold <= RSP_DATA;
    end
  end
  assign HOST_DATA_BUS_O = tx_hold;

  // Pin drivers and the interrupt level, all registered.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      HOST_DATA_BUS_OE <= 1'b0;
      ADDR_BIT1_OE     <= 1'b0;
      IRQ_OUT_N        <= 1'b1;
    end else begin
      HOST_DATA_BUS_OE <= ready && par_mode && !f[PIN_CS] && !f[PIN_RD]; // [R7]
      ADDR_BIT1_OE     <= ready && !par_mode && !f[PIN_CS]; // [R4] [R13]
      IRQ_OUT_N        <= !(ready && IRQ_PENDING && IRQ_PIN_ENABLE); // [R8]
    end
  end
  assign READY    = ready;
  assign PAR_MODE = par_mode;

  // Link side: the frame's own chip select clears the bit position between frames.
  assign link_rst = RST || CHIP_SEL_N;

  // Sampling on the rising edge serves clock modes 0 and 3 alike.
  always_ff @(posedge SCLK or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt <= BIT_ZERO;
      rx_sh   <= BYTE_ZERO;
    end else begin
      bit_cnt <= bit_cnt + 1'b1; // [R2] [R11]
      rx_sh   <= {rx_sh[DATA_W-2:0], ADDR_BIT0}; // [R3]
    end
  end

  // Two slots let the system side read one byte while the next is shifted in.
  always_ff @(posedge SCLK or posedge RST) begin
    if (RST) begin
      link_tgl   <= 1'b0;
      rx_slot[0] <= BYTE_ZERO;
      rx_slot[1] <= BYTE_ZERO;
    end else if (!CHIP_SEL_N && bit_cnt == BIT_LAST) begin
      link_tgl          <= !link_tgl;
      rx_slot[!link_tgl] <= {rx_sh[DATA_W-2:0], ADDR_BIT0};
    end
  end

  // Outgoing bits change on the falling edge; the first bit comes from the hold register.
  always_ff @(negedge SCLK or posedge link_rst) begin
    if (link_rst) begin
      tx_sh <= BYTE_ZERO;
    end else if (bit_cnt == BIT_ONE) begin
      tx_sh <= {tx_hold[DATA_W-2:0], 1'b0};
    end else begin
      tx_sh <= {tx_sh[DATA_W-2:0], 1'b0};
    end
  end
  assign ADDR_BIT1_O = (bit_cnt == BIT_ZERO) ? tx_hold[DATA_W-1] : tx_sh[DATA_W-1]; // [R4]

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  property p_mode_frozen;
    ready && $past(ready) |-> $stable(par_mode);
  endproperty
  a_mode_frozen: assert property (p_mode_frozen) else $error("mode changed after init"); // [R1]

  property p_bus_quiet_serial;
    !par_mode |-> !HOST_DATA_BUS_OE;
  endproperty
  a_bus_quiet_serial: assert property (p_bus_quiet_serial) else $error("bus driven"); // [R7]

  property p_miso_quiet_par;
    par_mode |-> !ADDR_BIT1_OE;
  endproperty
  a_miso_quiet_par: assert property (p_miso_quiet_par) else $error("addr1 driven"); // [R4]

  property p_irq_low;
    ready && IRQ_PENDING && IRQ_PIN_ENABLE |=> !IRQ_OUT_N;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("interrupt not shown"); // [R8]

  property p_irq_high;
    !(IRQ_PENDING && IRQ_PIN_ENABLE) |=> IRQ_OUT_N;
  endproperty
  a_irq_high: assert property (p_irq_high) else $error("interrupt without cause"); // [R8]

  property p_cs_gate;
    f[PIN_CS] |-> !par_ev ##1 !HOST_DATA_BUS_OE && !ADDR_BIT1_OE;
  endproperty
  a_cs_gate: assert property (p_cs_gate) else $error("answered while deselected"); // [R13]

  property p_init_hold;
    host_rst |=> !ready [*8];
  endproperty
  a_init_hold: assert property (p_init_hold) else $error("ready too early"); // [R10]

  property p_read_kind;
    par_ev && fall_rd && !fall_wr |=> pend_v && pend_w[DATA_W+ADDR_W +: KIND_W] == KIND_PAR_READ;
  endproperty
  a_read_kind: assert property (p_read_kind) else $error("read not queued"); // [R5]

  property p_write_word;
    par_ev && fall_wr |=> pend_v && pend_w == {KIND_PAR_WRITE, $past(f[PIN_A1]),
                                               $past(f[PIN_A0]), $past(f[PIN_D_LO +: DATA_W])};
  endproperty
  a_write_word: assert property (p_write_word) else $error("write word wrong"); // [R6] [R3] [R12]

  property p_spi_byte;
    spi_ev |=> pend_v && pend_w[DATA_W+ADDR_W +: KIND_W] == KIND_SPI_BYTE;
  endproperty
  a_spi_byte: assert property (p_spi_byte) else $error("serial byte lost"); // [R11]
endmodule : hps_top

// ### test/hps_host_model.sv
// Host model driving the serial link or the parallel bus of the host port.
`timescale 1ns/1ns
module hps_host_model
  import hps_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              miso,
  input  wire logic [DATA_W-1:0] bus,
  output logic                   sclk,
  output logic                   cs_n,
  output logic                   rd_n,
  output logic                   wr_n,
  output logic                   a0,
  output logic                   a1,
  output logic      [DATA_W-1:0] d,
  output logic      [DATA_W-1:0] rx
);
  // Idle levels: serial clock low, strobes and select high.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    a0 = 1'b0;
    a1 = 1'b0;
    d = 8'h00;
    rx = 8'h00;
  end

  // One strobe per byte, held 14 cycles so a read answer has time to arrive.
  task automatic par_cycle(input logic sel, input logic wr, input logic [ADDR_W-1:0] addr,
                           input logic [DATA_W-1:0] data);
    @(negedge clk);
    cs_n = ~sel;
    a0 = addr[0];
    a1 = addr[1];
    d = data;
    @(negedge clk);
    if (wr) wr_n = 1'b0;
    else rd_n = 1'b0;
    repeat (14) @(negedge clk);
    rx = bus;
    wr_n = 1'b1;
    rd_n = 1'b1;
    @(negedge clk);
    cs_n = 1'b1;
    d = ~data;
    repeat (4) @(negedge clk);
  endtask : par_cycle

  // Serial byte, most significant bit first; the clock stands still outside the frame.
  // The idle level is set while still deselected, so a mode change is no stray edge.
  // Select leads the first bit by six cycles because the data-out enable is synchronised.
  task automatic spi_byte(input logic cpol, input logic [DATA_W-1:0] tx);
    @(negedge clk);
    sclk = cpol;
    @(negedge clk);
    cs_n = 1'b0;
    repeat (6) @(negedge clk);
    #7;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      sclk = 1'b0;
      a0 = tx[i];
      #15;
      rx[i] = miso;
      sclk = 1'b1;
      #15;
    end
    sclk = cpol;
    a0 = ~tx[0];
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask : spi_byte
endmodule : hps_host_model

// ### test/host_port_spi_parallel_select_test.sv
// Self-checking bench for the host port: parallel bus, serial link, interrupt and reset.
`timescale 1ns/1ns
module host_port_spi_parallel_select_test;
  import hps_pkg::*;
  localparam int INIT = 20;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [KIND_W-1:0] kind;
  } hps_row_t;
  // Parallel writes: address and data in, request fields expected out.
  localparam hps_row_t ROWS [4] = '{'{2'h0, 8'h00, KIND_PAR_WRITE}, '{2'h1, 8'hff, KIND_PAR_WRITE},
                                    '{2'h2, 8'h5a, KIND_PAR_WRITE}, '{2'h3, 8'h81, KIND_PAR_WRITE}};
  logic              clk_sys = 1'b0;
  logic              rst = 1'b1;
  logic              strap = 1'b1;
  logic              rst_in_n = 1'b1;
  logic              irq_p = 1'b0;
  logic              irq_en = 1'b0;
  logic              req_ready = 1'b0;
  logic              rsp_valid = 1'b0;
  logic [DATA_W-1:0] rsp_data = 8'h00;
  logic              sclk, cs_n, rd_n, wr_n, a0, a1h, a1w, a1_o, a1_oe, d_oe;
  logic              irq_n, ready, par_mode, req_valid;
  logic [DATA_W-1:0] hd, d_o, bus, req_data;
  logic [KIND_W-1:0] req_kind;
  logic [ADDR_W-1:0] req_addr;
  int                err_total = 0;
  int                compares = 0;

  // Wire levels: the device wins while it drives, else the host's level shows.
  assign bus = d_oe ? d_o : hd;
  assign a1w = a1_oe ? a1_o : a1h;

  always #50 clk_sys = ~clk_sys;

  hps_top #(.INIT_CYCLES(INIT)) dut (
    .CLK_SYS(clk_sys), .RST(rst), .SCLK(sclk), .IFACE_MODE_STRAP(strap),
    .CHIP_SEL_N(cs_n), .RESET_IN_N(rst_in_n), .READ_STROBE_N(rd_n),
    .WRITE_STROBE_N(wr_n), .ADDR_BIT0(a0), .ADDR_BIT1_I(a1w), .ADDR_BIT1_O(a1_o),
    .ADDR_BIT1_OE(a1_oe), .HOST_DATA_BUS_I(bus), .HOST_DATA_BUS_O(d_o),
    .HOST_DATA_BUS_OE(d_oe), .IRQ_OUT_N(irq_n), .IRQ_PENDING(irq_p),
    .IRQ_PIN_ENABLE(irq_en), .READY(ready), .PAR_MODE(par_mode), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ_KIND(req_kind), .REQ_ADDR(req_addr), .REQ_DATA(req_data),
    .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data));

  hps_host_model host (
    .clk(clk_sys), .miso(a1w), .bus(bus), .sclk(sclk), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .a0(a0), .a1(a1h), .d(hd), .rx());

  // Verdict; also reached when a bounded wait runs out.
  task automatic final_report;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Waits for a request, compares it, then pops it with a one-cycle ready.
  task automatic get_req(input logic [KIND_W-1:0] k, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] v);
    int n;
    n = 0;
    while (req_valid !== 1'b1 && n < 60) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 60) begin
      err_total++;
      final_report();
    end
    check("req kind", k, req_kind);
    check("req addr", a, req_addr);
    check("req data", v, req_data);
    req_ready = 1'b1;
    @(negedge clk_sys);
    req_ready = 1'b0;
    // One edge passes with ready low, so a following call never re-raises it at once.
    @(negedge clk_sys);
  endtask : get_req

  // Ready must not rise before the initialisation count has run.
  task automatic wait_ready;
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 200) begin
      err_total++;
      final_report();
    end
    check("init length", 8'h01, 8'(n >= INIT));
  endtask : wait_ready

  task automatic do_reset(input logic mode);
    rst = 1'b1;
    strap = mode;
    repeat (20) @(negedge clk_sys);
    check("ready in reset", 8'h00, ready);
    check("irq in reset", 8'h01, irq_n);
    check("oe in reset", 8'h00, {a1_oe, d_oe});
    rst = 1'b0;
    wait_ready();
    check("mode", mode, par_mode);
  endtask : do_reset

  task automatic give_rsp(input logic [DATA_W-1:0] v);
    rsp_data = v;
    rsp_valid = 1'b1;
    @(negedge clk_sys);
    rsp_valid = 1'b0;
  endtask : give_rsp

  initial begin
    do_reset(1'b1);
    // The writes queue up in the FIFO while the engine stalls, then drain in order.
    foreach (ROWS[i]) host.par_cycle(1'b1, 1'b1, ROWS[i].addr, ROWS[i].data);
    check("miso oe in parallel", 8'h00, a1_oe);
    foreach (ROWS[i]) get_req(ROWS[i].kind, ROWS[i].addr, ROWS[i].data);
    host.par_cycle(1'b0, 1'b1, 2'h1, 8'h77);
    check("req without select", 8'h00, req_valid);
    fork
      host.par_cycle(1'b1, 1'b0, 2'h2, 8'h00);
      begin
        get_req(KIND_PAR_READ, 2'h2, 8'h00);
        give_rsp(8'h5c);
      end
    join
    check("read data", 8'h5c, host.rx);
    for (int k = 0; k < 4; k++) begin
      irq_p = k[0];
      irq_en = k[1];
      repeat (3) @(negedge clk_sys);
      check("irq", {7'h00, ~(k[0] & k[1])}, irq_n);
    end
    irq_p = 1'b0;
    rst_in_n = 1'b0;
    repeat (12) @(negedge clk_sys);
    check("ready under reset pin", 8'h00, ready);
    rst_in_n = 1'b1;
    wait_ready();
    // Serial mode: answer byte preloaded, then one byte in each clock mode.
    do_reset(1'b0);
    give_rsp(8'h96);
    host.spi_byte(1'b0, 8'h3c);
    get_req(KIND_SPI_BYTE, 2'h0, 8'h3c);
    check("miso byte", 8'h96, host.rx);
    host.spi_byte(1'b1, 8'hc3);
    get_req(KIND_SPI_BYTE, 2'h0, 8'hc3);
    host.par_cycle(1'b1, 1'b1, 2'h3, 8'h11);
    check("data oe in serial", 8'h00, d_oe);
    check("req in serial", 8'h00, req_valid);
    final_report();
  end
endmodule : host_port_spi_parallel_select_test
